// *** src/bsc_pkg.sv ***
// Package: configuration-space map and boot-segment field layout
package bsc_pkg;
    localparam int          ADDR_W            = 24;
    localparam int          CFG_W             = 8;
    // Configuration space and register map
    localparam logic [23:0] CFG_SPACE_LO      = 24'h800000;
    localparam logic [23:0] CFG_BASE          = 24'hF80000;
    localparam logic [23:0] ADDR_BOOT_SEG     = 24'hF80000;
    localparam logic [23:0] ADDR_GEN_SEG      = 24'hF80004;
    localparam logic [23:0] ADDR_OSC_SEL      = 24'hF80006;
    localparam logic [23:0] ADDR_OSC          = 24'hF80008;
    localparam logic [23:0] ADDR_WDT          = 24'hF8000A;
    localparam logic [23:0] ADDR_POR          = 24'hF8000C;
    localparam logic [23:0] ADDR_DBG          = 24'hF8000E;
    localparam int          NUM_CFG           = 7;
    // Table page bit that selects configuration space
    localparam int          PAGE_CFG_BIT      = 7;
    // Boot-segment byte fields
    localparam int          SEL_LSB           = 1;
    localparam int          SEL_MSB           = 3;
    localparam int          BWL_BIT           = 0;
    localparam logic [7:0]  BOOT_IMPL_MASK    = 8'h0F;
    localparam logic [7:0]  CFG_ERASED        = 8'hFF;
    // Boot segment select codes
    localparam logic [2:0]  SEL_NONE          = 3'h7;
    localparam logic [2:0]  SEL_SMALL_STD     = 3'h6;
    localparam logic [2:0]  SEL_SMALL_HIGH    = 3'h2;
    localparam logic [2:0]  SEL_LARGE_STD     = 3'h5;
    localparam logic [2:0]  SEL_LARGE_HIGH    = 3'h1;
    // Boot segment bounds
    localparam logic [23:0] BOOT_START        = 24'h000200;
    localparam logic [23:0] BOOT_END_SMALL    = 24'h000AFE;
    localparam logic [23:0] BOOT_END_LARGE    = 24'h0015FE;

    typedef enum logic [2:0] {
        BSC_SEC_NONE = 3'b001,
        BSC_SEC_STD  = 3'b010,
        BSC_SEC_HIGH = 3'b100
    } bsc_sec_t;
endpackage

// *** src/bsc_seg_if.sv ***
// Interface: decoded boot-segment view shared by decoder and top
`timescale 1ns/10ps
`default_nettype none
interface bsc_seg_if;
    import bsc_pkg::*;
    logic [7:0]  cfg_byte;
    logic        seg_valid;
    logic        reserved;
    bsc_sec_t    sec;
    logic [23:0] seg_end;
    logic        write_lock;
    modport dec (input cfg_byte, output seg_valid, output reserved, output sec,
                 output seg_end, output write_lock);
    modport top (output cfg_byte, input seg_valid, input reserved, input sec,
                 input seg_end, input write_lock);
endinterface
`default_nettype wire

// *** src/bsc_seg_decode.sv ***
// Boot-segment select and write-lock decoder
`timescale 1ns/10ps
`default_nettype none
module bsc_seg_decode (
    bsc_seg_if.dec seg
);
    import bsc_pkg::*;
    logic [2:0] sel;

    always_comb begin
        sel            = seg.cfg_byte[SEL_MSB:SEL_LSB];
        seg.seg_valid  = 1'b0;
        seg.reserved   = 1'b0;
        seg.sec        = BSC_SEC_NONE;
        seg.seg_end    = BOOT_START;
        unique case (sel)
            SEL_SMALL_STD: begin
                seg.seg_valid = 1'b1;
                seg.sec       = BSC_SEC_STD;
                seg.seg_end   = BOOT_END_SMALL;
            end
            SEL_SMALL_HIGH: begin
                seg.seg_valid = 1'b1;
                seg.sec       = BSC_SEC_HIGH;
                seg.seg_end   = BOOT_END_SMALL;
            end
            SEL_LARGE_STD: begin
                seg.seg_valid = 1'b1;
                seg.sec       = BSC_SEC_STD;
                seg.seg_end   = BOOT_END_LARGE;
            end
            SEL_LARGE_HIGH: begin
                seg.seg_valid = 1'b1;
                seg.sec       = BSC_SEC_HIGH;
                seg.seg_end   = BOOT_END_LARGE;
            end
            SEL_NONE: begin
                seg.seg_valid = 1'b0;
            end
            default: begin
                seg.reserved  = 1'b1;
            end
        endcase
        // Lock only meaningful when a segment exists
        seg.write_lock = seg.seg_valid & ~seg.cfg_byte[BWL_BIT];
    end
endmodule
`default_nettype wire

// *** src/bsc_top.sv ***
// Configuration-word map and boot-segment protection
`timescale 1ns/10ps
`default_nettype none
module bsc_top (
    // Clock and reset
    input  wire logic                     mclk,
    input  wire logic                     resetn,
    input  wire logic                     clk_en,
    // Non-volatile configuration array, sampled after reset
    input  wire logic [bsc_pkg::NUM_CFG*bsc_pkg::CFG_W-1:0] nv_cfg,
    // Table access from the core
    input  wire logic [7:0]               table_page_register,
    input  wire logic [15:0]              tbl_offset,
    input  wire logic                     tbl_rd,
    input  wire logic                     tbl_wr,
    output logic      [7:0]               tbl_rdata,
    output logic                          tbl_rvalid,
    output logic                          tbl_wr_ok,
    output logic                          tbl_wr_blocked,
    // Decoded boot-segment state
    output logic                          boot_seg_valid,
    output logic                          boot_seg_high_sec,
    output logic                          boot_seg_reserved,
    output logic      [23:0]              boot_seg_end,
    output logic                          boot_segment_write_lock,
    output logic      [bsc_pkg::NUM_CFG*bsc_pkg::CFG_W-1:0] cfg_values
);
    import bsc_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Configuration capture after reset release
    logic [CFG_W-1:0] cfg_q [NUM_CFG];
    logic [CFG_W-1:0] cfg_d [NUM_CFG];
    logic             loaded_q;
    logic             loaded_d;

    always_comb begin
        loaded_d = loaded_q | clk_en;
        for (int i = 0; i < NUM_CFG; i++) begin
            cfg_d[i] = cfg_q[i];
            if (!loaded_q && clk_en)
                cfg_d[i] = nv_cfg[i*CFG_W +: CFG_W];
        end
        cfg_d[0] = cfg_d[0] & BOOT_IMPL_MASK;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            loaded_q <= 1'b0;
            for (int i = 0; i < NUM_CFG; i++)
                cfg_q[i] <= CFG_ERASED & (i == 0 ? BOOT_IMPL_MASK : 8'hFF);
        end else begin
            loaded_q <= loaded_d;
            for (int i = 0; i < NUM_CFG; i++)
                cfg_q[i] <= cfg_d[i];
        end
    end

    genvar g;
    generate
        for (g = 0; g < NUM_CFG; g++) begin : g_out
            assign cfg_values[g*CFG_W +: CFG_W] = cfg_q[g];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Boot-segment decode
    bsc_seg_if seg ();
    assign seg.cfg_byte = cfg_q[0];

    bsc_seg_decode u_dec (
        .seg (seg)
    );

    ////////////////////////////////////////////////////////////////////////
    // Table access
    logic [23:0] tbl_addr;
    logic        in_cfg;
    logic        hit;
    logic [2:0]  idx;
    logic        in_boot;

    always_comb begin
        tbl_addr = {table_page_register, tbl_offset};
        in_cfg   = table_page_register[PAGE_CFG_BIT];
        hit      = 1'b1;
        idx      = 3'd0;
        unique case (tbl_addr)
            ADDR_BOOT_SEG: idx = 3'd0;
            ADDR_GEN_SEG:  idx = 3'd1;
            ADDR_OSC_SEL:  idx = 3'd2;
            ADDR_OSC:      idx = 3'd3;
            ADDR_WDT:      idx = 3'd4;
            ADDR_POR:      idx = 3'd5;
            ADDR_DBG:      idx = 3'd6;
            default:       hit = 1'b0;
        endcase
        in_boot = !in_cfg && seg.seg_valid
               && tbl_addr >= BOOT_START && tbl_addr <= seg.seg_end;
    end

    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       rvalid_q;
    logic       rvalid_d;
    logic       wok_q;
    logic       wok_d;
    logic       wblk_q;
    logic       wblk_d;

    always_comb begin
        rdata_d  = rdata_q;
        rvalid_d = 1'b0;
        wok_d    = 1'b0;
        wblk_d   = 1'b0;
        if (tbl_rd && in_cfg) begin
            rvalid_d = 1'b1;
            rdata_d  = hit ? cfg_q[idx] : 8'h00;
        end
        if (tbl_wr) begin
            if (in_cfg) begin
                wblk_d = 1'b1;
            end else if (in_boot && seg.write_lock) begin
                wblk_d = 1'b1;
            end else begin
                wok_d  = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rdata_q  <= 8'h00;
            rvalid_q <= 1'b0;
            wok_q    <= 1'b0;
            wblk_q   <= 1'b0;
        end else if (clk_en) begin
            rdata_q  <= rdata_d;
            rvalid_q <= rvalid_d;
            wok_q    <= wok_d;
            wblk_q   <= wblk_d;
        end
    end

    assign tbl_rdata               = rdata_q;
    assign tbl_rvalid              = rvalid_q;
    assign tbl_wr_ok               = wok_q;
    assign tbl_wr_blocked          = wblk_q;
    assign boot_seg_valid          = seg.seg_valid;
    assign boot_seg_high_sec       = (seg.sec == BSC_SEC_HIGH);
    assign boot_seg_reserved       = seg.reserved;
    assign boot_seg_end            = seg.seg_end;
    assign boot_segment_write_lock = seg.write_lock;
endmodule
`default_nettype wire

// *** sim/bsc_props.sv ***
// Checker: port-level properties of the boot-segment protection block
`timescale 1ns/10ps
`default_nettype none
module bsc_props (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        resetn,
    input wire logic        clk_en,
    // Table access
    input wire logic [7:0]  table_page_register,
    input wire logic [15:0] tbl_offset,
    input wire logic        tbl_rd,
    input wire logic        tbl_wr,
    input wire logic [7:0]  tbl_rdata,
    input wire logic        tbl_rvalid,
    input wire logic        tbl_wr_ok,
    input wire logic        tbl_wr_blocked,
    // Boot-segment state
    input wire logic        boot_seg_valid,
    input wire logic        boot_seg_high_sec,
    input wire logic        boot_seg_reserved,
    input wire logic [23:0] boot_seg_end,
    input wire logic        boot_segment_write_lock,
    input wire logic [bsc_pkg::NUM_CFG*bsc_pkg::CFG_W-1:0] cfg_values
);
    import bsc_pkg::*;
    logic [23:0] a;
    logic [2:0]  c;
    logic        p;
    assign a = {table_page_register, tbl_offset};
    assign c = cfg_values[SEL_MSB:SEL_LSB];
    assign p = table_page_register[PAGE_CFG_BIT];
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    rd_answer_a: assert property (tbl_rd && clk_en && p |=> tbl_rvalid)
        else $error("config read not answered");
    rvalid_cause_a: assert property ($past(clk_en) && tbl_rvalid
        |-> $past(tbl_rd && p))
        else $error("read answer without config read");
    cfg_wr_refused_a: assert property (tbl_wr && clk_en && p
        |=> tbl_wr_blocked && !tbl_wr_ok)
        else $error("config write not refused");
    lock_wr_blocked_a: assert property (tbl_wr && clk_en && !p && boot_segment_write_lock
        && a >= BOOT_START && a <= boot_seg_end |=> tbl_wr_blocked)
        else $error("locked segment write not blocked");
    free_wr_ok_a: assert property (tbl_wr && clk_en && !p && !boot_segment_write_lock
        |=> tbl_wr_ok)
        else $error("unlocked write refused");
    lock_level_a: assert property (boot_segment_write_lock
        == (boot_seg_valid && !cfg_values[BWL_BIT]))
        else $error("write lock level wrong");
    seg_decode_a: assert property (boot_seg_valid == (c inside {3'h6, 3'h2, 3'h5, 3'h1})
        && boot_seg_high_sec == (c inside {3'h2, 3'h1})
        && boot_seg_reserved == (c inside {3'h3, 3'h4, 3'h0}))
        else $error("segment decode wrong");
    seg_end_a: assert property (boot_seg_end == (!boot_seg_valid ? BOOT_START
        : c[1] ? BOOT_END_SMALL : BOOT_END_LARGE))
        else $error("segment end wrong");
    boot_read_a: assert property (tbl_rd && clk_en && a == ADDR_BOOT_SEG
        |=> tbl_rdata == {4'h0, cfg_values[3:0]})
        else $error("boot byte read wrong");
    cover property (tbl_wr_blocked);
    cover property (tbl_rvalid);
    cover property (boot_segment_write_lock);
endmodule
bind bsc_top bsc_props u_bsc_props (.mclk, .resetn, .clk_en, .table_page_register, .tbl_offset,
    .tbl_rd, .tbl_wr, .tbl_rdata, .tbl_rvalid, .tbl_wr_ok, .tbl_wr_blocked, .boot_seg_valid,
    .boot_seg_high_sec, .boot_seg_reserved, .boot_seg_end, .boot_segment_write_lock, .cfg_values);
`default_nettype wire

// *** sim/bsc_core_model.sv ***
// Core model: issues table reads and writes one at a time
`timescale 1ns/10ps
`default_nettype none
module bsc_core_model (
    // Clock
    input  wire logic        mclk,
    // Answer from the device
    input  wire logic [7:0]  tbl_rdata,
    input  wire logic        tbl_rvalid,
    input  wire logic        tbl_wr_ok,
    input  wire logic        tbl_wr_blocked,
    // Table request
    output var  logic [7:0]  table_page_register,
    output var  logic [15:0] tbl_offset,
    output var  logic        tbl_rd,
    output var  logic        tbl_wr
);
    initial begin
        {table_page_register, tbl_offset} = 24'h000000;
        {tbl_rd, tbl_wr} = 2'h0;
    end
    task automatic acc(input logic [23:0] a, input logic w, output logic [7:0] d,
                       output logic [2:0] r);
        @(posedge mclk);
        {table_page_register, tbl_offset} <= a;
        tbl_rd <= !w;
        tbl_wr <= w;
        @(posedge mclk);
        tbl_rd <= 1'b0;
        tbl_wr <= 1'b0;
        // Released address shows the inverse
        {table_page_register, tbl_offset} <= ~a;
        @(negedge mclk);
        d = tbl_rdata;
        r = {tbl_rvalid, tbl_wr_ok, tbl_wr_blocked};
    endtask
endmodule
`default_nettype wire

// *** sim/bsc_top_test.sv ***
// Testbench: config reads, refused writes and boot-segment decode
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, s) begin \
    checks_done++; \
    if ((s) !== (e)) begin \
        fail_count++; \
        $display("Error %s exp %h got %h", n, e, s); \
    end \
end
module bsc_top_test;
    import bsc_pkg::*;
    logic                     mclk, resetn, ce, rd, wr, rv, ok, bl, sv, hs, rs, lk;
    logic [NUM_CFG*CFG_W-1:0] nv, cv, v;
    logic [7:0]               pg, rdat, d;
    logic [15:0]              off;
    logic [23:0]              se, e;
    logic [2:0]               r;
    logic                     val;
    int                       fail_count = 0, checks_done = 0, cyc = 0;
    bsc_top u_bsc_top (.mclk(mclk), .resetn(resetn), .clk_en(ce), .nv_cfg(nv),
        .table_page_register(pg), .tbl_offset(off), .tbl_rd(rd), .tbl_wr(wr),
        .tbl_rdata(rdat), .tbl_rvalid(rv), .tbl_wr_ok(ok), .tbl_wr_blocked(bl),
        .boot_seg_valid(sv), .boot_seg_high_sec(hs), .boot_seg_reserved(rs),
        .boot_seg_end(se), .boot_segment_write_lock(lk), .cfg_values(cv));
    bsc_core_model u_bsc_core_model (.mclk(mclk), .tbl_rdata(rdat), .tbl_rvalid(rv),
        .tbl_wr_ok(ok), .tbl_wr_blocked(bl), .table_page_register(pg), .tbl_offset(off),
        .tbl_rd(rd), .tbl_wr(wr));
    task automatic results;
        $display("checks %0d errors %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic rst(input logic [NUM_CFG*CFG_W-1:0] x);
        @(posedge mclk);
        nv <= x;
        resetn <= 1'b0;
        repeat (3) @(posedge mclk);
        resetn <= 1'b1;
        repeat (2) @(posedge mclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        resetn = 1'b0;
        ce = 1'b1;
        nv = '1;
        rst('1);
        `CHK("cfg", {{6{8'hFF}}, 8'h0F}, cv)
        `CHK("seg", 3'h0, {sv, lk, rs})
        u_bsc_core_model.acc(24'h000300, 1'b1, d, r);
        `CHK("free wr", 3'h2, r)
        v = 56'h554433221100A5;
        rst(v);
        for (int i = 0; i < NUM_CFG; i++) begin
            e = (i == 0) ? ADDR_BOOT_SEG : ADDR_GEN_SEG + 24'(2 * (i - 1));
            u_bsc_core_model.acc(e, 1'b0, d, r);
            `CHK("reg", (i == 0) ? 8'h05 : v[8*i+:8], d)
            `CHK("rvalid", 3'h4, r)
        end
        u_bsc_core_model.acc(24'hF80002, 1'b0, d, r);
        `CHK("unmapped", 11'h004, {d, r})
        u_bsc_core_model.acc(24'h800000, 1'b0, d, r);
        `CHK("space lo", 11'h004, {d, r})
        u_bsc_core_model.acc(24'hF80000, 1'b1, d, r);
        `CHK("cfg wr", 3'h1, r)
        u_bsc_core_model.acc(24'hF80000, 1'b0, d, r);
        `CHK("kept", 8'h05, d)
        u_bsc_core_model.acc(24'h000000, 1'b0, d, r);
        `CHK("user rd", 3'h0, r)
        u_bsc_core_model.acc(24'h000300, 1'b1, d, r);
        `CHK("unlocked", 3'h2, r)
        // Enable low: read ignored, answer and data held
        @(posedge mclk);
        ce <= 1'b0;
        u_bsc_core_model.acc(ADDR_GEN_SEG, 1'b0, d, r);
        `CHK("frozen", 11'h028, {d, r})
        @(posedge mclk);
        ce <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rst({{6{8'hFF}}, 4'hF, 3'(i), 1'b0});
            val = (i == 6 || i == 2 || i == 5 || i == 1);
            e = !val ? BOOT_START : (i == 6 || i == 2) ? BOOT_END_SMALL : BOOT_END_LARGE;
            `CHK("valid", val, sv)
            `CHK("high", (i == 2 || i == 1), hs)
            `CHK("rsvd", (i == 3 || i == 4 || i == 0), rs)
            `CHK("end", e, se)
            `CHK("lock", val, lk)
            u_bsc_core_model.acc(e, 1'b1, d, r);
            `CHK("wr end", val ? 3'h1 : 3'h2, r)
            u_bsc_core_model.acc(BOOT_START, 1'b1, d, r);
            `CHK("wr start", val ? 3'h1 : 3'h2, r)
            u_bsc_core_model.acc(e + 24'h000002, 1'b1, d, r);
            `CHK("wr past", 3'h2, r)
        end
        results();
    end
endmodule
`default_nettype wire
